// [shared/etc8_pkg.sv]
// Constants shared by the 8-bit timer/event counter, its checker and its testbench.
// Assumes an APB slave with 32-bit data on pclk; registers sit in low bits.

package etc8_pkg;

   // -----------------------------------------------------------------
   // Register byte addresses
   // -----------------------------------------------------------------
   localparam logic [11:0] ADDR_COUNT_VALUE = 12'h000;
   localparam logic [11:0] ADDR_CONTROL     = 12'h004;
   localparam logic [11:0] ADDR_INTC        = 12'h008;
   localparam logic [11:0] ADDR_PORT_A      = 12'h00c;
   localparam logic [11:0] ADDR_OPTION      = 12'h010;

   // -----------------------------------------------------------------
   // Control fields and reset values
   // -----------------------------------------------------------------
   localparam int          PSC_LSB      = 0;
   localparam int          PSC_MSB      = 2;
   localparam int          EDGE_BIT     = 3;
   localparam int          RUN_BIT      = 4;
   localparam int          MODE_LSB     = 6;
   localparam int          MODE_MSB     = 7;
   localparam logic [7:0]  CTRL_RESET   = 8'h08;
   localparam logic [7:0]  CTRL_WMASK   = 8'hdf;

   // Interrupt control fields
   localparam int          IRQ_EN_BIT   = 3;
   localparam int          OVF_FLAG_BIT = 6;

   // Port A line used by the divider output
   localparam int          PA_DIV_BIT   = 3;
   localparam logic [7:0]  PA_RESET     = 8'hff;

   // Option register fields
   localparam int          OPT_DIV_BIT  = 0;

   localparam logic [7:0]  COUNT_TOP    = 8'hff;
   localparam logic [7:0]  COUNT_ONE    = 8'h01;

   // -----------------------------------------------------------------
   // Operating modes
   // -----------------------------------------------------------------
   localparam logic [1:0]  MODE_UNUSED  = 2'h0;
   localparam logic [1:0]  MODE_EVENT   = 2'h1;
   localparam logic [1:0]  MODE_TIMER   = 2'h2;
   localparam logic [1:0]  MODE_PULSE   = 2'h3;

   typedef enum logic [1:0] {
      ETC8_PW_IDLE,
      ETC8_PW_MEASURE,
      ETC8_PW_DONE
   } etc8_pw_state_e;

endpackage

// [rtl/etc8_prescaler.sv]
// Free-running divider that yields one-cycle count ticks.
// Assumes pclk domain; clears under asynchronous reset.

module etc8_prescaler #(
   parameter int DIV_BITS = 7
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] sel,
   input  wire logic       hold,
   output logic            tick
);

   logic [DIV_BITS-1:0] div_count;
   logic [DIV_BITS:0]   mask;

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   // Advances every edge except while a read holds off the clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= '0;
      end else if (!hold) begin
         div_count <= div_count + 1'b1;
      end
   end

   // Tick when low sel bits of the divider are all ones (sel 0 = every cycle)
   always_comb begin
      mask = ((DIV_BITS+1)'(1) << sel) - 1'b1;
      tick = !hold && ((div_count & mask[DIV_BITS-1:0]) == mask[DIV_BITS-1:0]);
   end

endmodule

// [rtl/etc8_timer.sv]
// 8-bit timer/event counter with preload, prescaler and divider output.
// Assumes an APB master on pclk; the count pin is async, wake is a registered output.

module etc8_timer #(
   parameter int DIV_BITS = 7
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        warm_reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        count_pin,
   output logic             freq_divider_out,
   output logic             irq,
   output logic             wake
);

   logic [7:0]               count_value;
   logic [7:0]               preload;
   logic [7:0]               counter_control;
   logic                     overflow_flag;
   logic                     overflow_irq_enable;
   logic [7:0]               port_a;
   logic                     div_option;
   logic                     div_toggle;
   logic                     pin_meta;
   logic                     pin_sync;
   logic                     pin_prev;
   logic                     wr_en;
   logic                     rd_en;
   logic                     hit;
   logic                     count_rd;
   logic                     presc_tick;
   logic                     rise;
   logic                     fall;
   logic                     tick;
   logic                     overflow;
   logic                     pw_start;
   logic                     pw_stop;
   logic                     lane0;
   logic [1:0]               mode;
   logic                     running;
   logic                     sel_count;
   logic                     sel_control;
   logic                     sel_intc;
   logic                     sel_port_a;
   logic                     sel_option;
   logic                     wr_count;
   logic                     wr_control;
   logic                     wr_intc;
   logic                     wr_port_a;
   logic                     wr_option;
   logic                     count_load;
   logic                     pw_finish;
   etc8_pkg::etc8_pw_state_e pw_state;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign lane0   = pstrb[0];
   assign pslverr = psel && penable && !hit;

   // One select per mapped register; any other address is refused
   assign sel_count   = (paddr == etc8_pkg::ADDR_COUNT_VALUE);
   assign sel_control = (paddr == etc8_pkg::ADDR_CONTROL);
   assign sel_intc    = (paddr == etc8_pkg::ADDR_INTC);
   assign sel_port_a  = (paddr == etc8_pkg::ADDR_PORT_A);
   assign sel_option  = (paddr == etc8_pkg::ADDR_OPTION);
   assign hit         = sel_count || sel_control || sel_intc || sel_port_a || sel_option;

   // Writes land only with byte lane 0 enabled
   assign wr_count    = wr_en && lane0 && sel_count;
   assign wr_control  = wr_en && lane0 && sel_control;
   assign wr_intc     = wr_en && lane0 && sel_intc;
   assign wr_port_a   = wr_en && lane0 && sel_port_a;
   assign wr_option   = wr_en && lane0 && sel_option;

   // A counter read freezes the count clock for its access cycle
   assign count_rd    = rd_en && sel_count;

   // Mode field and run bit as seen by the counting logic
   assign mode    = counter_control[etc8_pkg::MODE_MSB:etc8_pkg::MODE_LSB];
   assign running = counter_control[etc8_pkg::RUN_BIT];

   // ----------------------------------------------------------------
   // Pin synchroniser and edge detect
   // ----------------------------------------------------------------
   // Two flops before any logic sees the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= count_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // One-cycle strobes on each synchronised pin edge
   assign rise = pin_sync && !pin_prev;
   assign fall = !pin_sync && pin_prev;

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Internal count clock, frozen together with the counter during a read
   etc8_prescaler #(
      .DIV_BITS (DIV_BITS)
   ) u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .sel     (counter_control[etc8_pkg::PSC_MSB:etc8_pkg::PSC_LSB]),
      .hold    (count_rd),
      .tick    (presc_tick)
   );

   // ----------------------------------------------------------------
   // Count clock selection
   // ----------------------------------------------------------------
   // Edge select picks start/stop level for pulse measurement
   assign pw_start = counter_control[etc8_pkg::EDGE_BIT] ? rise : fall;
   assign pw_stop  = counter_control[etc8_pkg::EDGE_BIT] ? fall : rise;

   // Count strobe per mode; blocked during a counter read
   always_comb begin
      tick = 1'b0;
      case (mode)
         etc8_pkg::MODE_EVENT: begin
            tick = counter_control[etc8_pkg::EDGE_BIT] ? fall : rise;
         end
         etc8_pkg::MODE_TIMER: begin
            tick = presc_tick;
         end
         etc8_pkg::MODE_PULSE: begin
            tick = presc_tick && (pw_state == etc8_pkg::ETC8_PW_MEASURE);
         end
         default: begin
            tick = 1'b0;
         end
      endcase
      tick = tick && running && !count_rd;
   end

   assign overflow = tick && (count_value == etc8_pkg::COUNT_TOP);

   // Stop edge while measuring ends the single measurement
   assign pw_finish = (mode == etc8_pkg::MODE_PULSE) && (pw_state == etc8_pkg::ETC8_PW_MEASURE)
                      && pw_stop;

   // A stopped counter takes a preload write directly
   assign count_load = wr_count && !running;

   // ----------------------------------------------------------------
   // Pulse-width sequencer
   // ----------------------------------------------------------------
   // Waits for the start edge, measures, then passes through done back to idle as the finish clears the run bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_state <= etc8_pkg::ETC8_PW_IDLE;
      end else if (mode != etc8_pkg::MODE_PULSE || !running) begin
         pw_state <= etc8_pkg::ETC8_PW_IDLE;
      end else begin
         case (pw_state)
            etc8_pkg::ETC8_PW_IDLE: begin
               if (pw_start) begin
                  pw_state <= etc8_pkg::ETC8_PW_MEASURE;
               end
            end
            etc8_pkg::ETC8_PW_MEASURE: begin
               if (pw_finish) begin
                  pw_state <= etc8_pkg::ETC8_PW_DONE;
               end
            end
            etc8_pkg::ETC8_PW_DONE: begin
               pw_state <= etc8_pkg::ETC8_PW_DONE;
            end
            default: begin
               pw_state <= etc8_pkg::ETC8_PW_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Cold reset only; warm reset leaves contents untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_control <= etc8_pkg::CTRL_RESET;
      end else if (wr_control) begin
         counter_control <= pwdata[7:0] & etc8_pkg::CTRL_WMASK;
      end else if (pw_finish) begin
         counter_control[etc8_pkg::RUN_BIT] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Preload and counter
   // ----------------------------------------------------------------
   // Preload always takes the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preload <= '0;
      end else if (wr_count) begin
         preload <= pwdata[7:0];
      end
   end

   // Counter: load when stopped, reload on overflow, else count up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value <= '0;
      end else if (count_load) begin
         count_value <= pwdata[7:0];
      end else if (overflow) begin
         count_value <= preload;
      end else if (tick) begin
         count_value <= count_value + etc8_pkg::COUNT_ONE;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt control, port A and options
   // ----------------------------------------------------------------
   // Interrupt enable is purely software owned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_irq_enable <= 1'b0;
      end else if (wr_intc) begin
         overflow_irq_enable <= pwdata[etc8_pkg::IRQ_EN_BIT];
      end
   end

   // Overflow sets the flag; a set beats a same-cycle software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
      end else if (overflow) begin
         overflow_flag <= 1'b1;
      end else if (wr_intc) begin
         overflow_flag <= pwdata[etc8_pkg::OVF_FLAG_BIT];
      end
   end

   // Port A output latch; line 3 gates the divider output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a <= etc8_pkg::PA_RESET;
      end else if (wr_port_a) begin
         port_a <= pwdata[7:0];
      end
   end

   // Option bit routes the divider onto port A line 3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_option <= 1'b0;
      end else if (wr_option) begin
         div_option <= pwdata[etc8_pkg::OPT_DIV_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Divider output, interrupt and wake
   // ----------------------------------------------------------------
   // Toggle per overflow gives half the overflow rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_toggle <= 1'b0;
      end else if (overflow) begin
         div_toggle <= !div_toggle;
      end
   end

   // Divider pin: follows port A line 3, gated by the toggle when selected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_divider_out <= 1'b0;
      end else if (div_option) begin
         freq_divider_out <= port_a[etc8_pkg::PA_DIV_BIT] && div_toggle;
      end else begin
         freq_divider_out <= port_a[etc8_pkg::PA_DIV_BIT];
      end
   end

   // Interrupt request line, masked by the enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= overflow_flag && overflow_irq_enable;
      end
   end

   // One-cycle wake pulse per overflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake <= 1'b0;
      end else begin
         wake <= overflow;
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Read data is zero outside a read access
   always_comb begin
      prdata = '0;
      if (rd_en) begin
         case (paddr)
            etc8_pkg::ADDR_COUNT_VALUE: prdata[7:0] = count_value;
            etc8_pkg::ADDR_CONTROL:     prdata[7:0] = counter_control;
            etc8_pkg::ADDR_INTC: begin
               prdata[etc8_pkg::IRQ_EN_BIT]   = overflow_irq_enable;
               prdata[etc8_pkg::OVF_FLAG_BIT] = overflow_flag;
            end
            etc8_pkg::ADDR_PORT_A:      prdata[7:0] = port_a;
            etc8_pkg::ADDR_OPTION:      prdata[etc8_pkg::OPT_DIV_BIT] = div_option;
            default:                    prdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Warm reset
   // ----------------------------------------------------------------
   // A warm reset leaves control, counter and preload as they are, so
   // the input is only observed here and drives no state
   logic warm_unused;
   assign warm_unused = warm_reset_n;

endmodule

// [sim/etc8_pin_model.sv]
// Model of the external event or pulse source on the count pin.
// Assumes the bench sets the wanted level; the pin follows it after a fixed 37 ns delay.
module etc8_pin_model (
   input  wire logic level,
   output logic      count_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pin follows the request with a delay unrelated to pclk
   initial count_pin = 1'h0;
   always @(level) count_pin <= #37 level;
endmodule

// [sim/etc8_checker.sv]
// Port-level assertions for the 8-bit timer.
// Assumes one pclk domain with presetn as async active-low reset.
module etc8_checker #(
   parameter int DIV_BITS = 7
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        warm_reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        count_pin,
   input wire logic        freq_divider_out,
   input wire logic        irq,
   input wire logic        wake
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       acc;
   logic       wr;
   logic       rd_ctl;
   logic [7:0] ctl_exp;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access qualifiers
   assign acc    = psel && penable;
   assign wr     = acc && pwrite;
   assign rd_ctl = acc && !pwrite && paddr == etc8_pkg::ADDR_CONTROL;
   // Last control value written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_exp <= etc8_pkg::CTRL_RESET;
      end else if (wr && pstrb[0] && paddr == etc8_pkg::ADDR_CONTROL) begin
         ctl_exp <= pwdata[7:0];
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_ready_access: assert property (acc |-> pready)
      else $error("pready low in access");
   a_rdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
   a_slverr_unmapped: assert property (acc && paddr > etc8_pkg::ADDR_OPTION |-> pslverr)
      else $error("no error on unmapped access");
   a_slverr_mapped: assert property (acc && paddr <= etc8_pkg::ADDR_OPTION
      && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped access");
   a_ctl_spare: assert property (rd_ctl |-> prdata[5] == 1'h0)
      else $error("spare control bit read as one");
   a_ctl_readback: assert property (rd_ctl |-> {prdata[7:6], prdata[3:0]}
      == {ctl_exp[7:6], ctl_exp[3:0]})
      else $error("control readback wrong");
   a_div_toggle: assert property ($changed(freq_divider_out) |-> $past(wake)
      || $past(wr, 2) || !$past(presetn, 2)) else $error("divider moved alone");
   a_irq_cause: assert property ($rose(irq) |-> $past(wake)
      || $past(wr) || $past(wr, 2)) else $error("irq rose with no cause");
   c_wake: cover property (wake);
   c_irq: cover property ($rose(irq));
   c_div: cover property ($rose(freq_divider_out));
endmodule

// [sim/testbench.sv]
// Self-checking bench for the 8-bit timer over APB.
// Assumes the package, design, pin model and checker are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] CNT = etc8_pkg::ADDR_COUNT_VALUE;
   localparam logic [11:0] CTL = etc8_pkg::ADDR_CONTROL;
   localparam logic [11:0] INT = etc8_pkg::ADDR_INTC;
   localparam logic [11:0] PA  = etc8_pkg::ADDR_PORT_A;
   localparam logic [11:0] OPT = etc8_pkg::ADDR_OPTION;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        warm_reset_n = 1'h1;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        count_pin;
   logic        freq_divider_out;
   logic        irq;
   logic        wake;
   logic        pin_level = 1'h0;
   logic        mon = 1'h0;
   logic        last_div = 1'h0;
   logic        se;
   logic [31:0] q;
   logic [31:0] v;
   int          fails = 0;
   int          total_checks = 0;
   int          wakes = 0;
   int          toggles = 0;
   always #50 pclk = ~pclk;
   etc8_timer #(.DIV_BITS(7)) dut (.pclk, .presetn, .warm_reset_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .count_pin,
      .freq_divider_out, .irq, .wake);
   etc8_pin_model pin (.level(pin_level), .count_pin);
   // Counts overflows and divider toggles while enabled
   always @(negedge pclk) begin
      if (mon && wake === 1'h1) wakes++;
      if (mon && freq_divider_out !== last_div) toggles++;
      last_div = freq_divider_out;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= {24'h0, d};
      pstrb  <= {4{wr}};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) begin
            fails++;
            end_of_test();
         end
      end while (pready !== 1'h1);
      q = prdata;
      se = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic w(input logic [11:0] a, input logic [7:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic r(input logic [11:0] a, input logic [7:0] e);
      apb(1'h0, a, 8'h0);
      check(q, {24'h0, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge pclk);
   endtask
   task automatic wait_wake(input int lim);
      int n;
      n = 0;
      while (wake !== 1'h1) begin
         @(negedge pclk);
         n++;
         if (n > lim) begin
            fails++;
            end_of_test();
         end
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      r(CTL, 8'h08);
      check({31'h0, freq_divider_out}, 32'h1);
      w(CTL, 8'h2f);
      r(CTL, 8'h0f);
      apb(1'h0, 12'h040, 8'h0);
      check({se, q[30:0]}, 32'h80000000);
      w(CNT, 8'h5a);
      r(CNT, 8'h5a);
      // Slow timer: preload rewritten while running
      w(CTL, 8'h87);
      w(CNT, 8'hf0);
      w(CTL, 8'h97);
      w(CNT, 8'h80);
      apb(1'h0, CNT, 8'h0);
      check({28'h0, q[7:4]}, 32'hf);
      wait_wake(4000);
      r(CNT, 8'h80);
      r(INT, 8'h40);
      check({31'h0, irq}, 32'h0);
      w(INT, 8'h48);
      cyc(3);
      check({31'h0, irq}, 32'h1);
      w(INT, 8'h08);
      cyc(3);
      check({31'h0, irq}, 32'h0);
      r(CTL, 8'h97);
      w(CTL, 8'h87);
      apb(1'h0, CNT, 8'h0);
      v = q;
      cyc(300);
      r(CNT, v[7:0]);
      // Divider output at the fastest prescaler rate, preload fe giving an overflow every second cycle
      w(OPT, 8'h01);
      w(CTL, 8'h80);
      w(CNT, 8'hfe);
      mon = 1'h1;
      w(CTL, 8'h90);
      cyc(40);
      w(CTL, 8'h80);
      cyc(5);
      mon = 1'h0;
      check(toggles, wakes);
      check({31'h0, wakes > 10}, 32'h1);
      w(PA, 8'hf7);
      w(CTL, 8'h90);
      cyc(20);
      check({31'h0, freq_divider_out}, 32'h0);
      // Event counting on each edge polarity
      w(CTL, 8'h40);
      w(CNT, 8'h20);
      for (int e = 0; e < 2; e++) begin
         w(CTL, {4'h5, e[0], 3'h0});
         pin_level <= 1'h1;
         cyc(10);
         r(CNT, 8'h21);
         pin_level <= 1'h0;
         cyc(10);
         r(CNT, {6'h08, e[0], ~e[0]});
      end
      // Pulse width of a high level
      w(CTL, 8'hc8);
      w(CNT, 8'h00);
      w(CTL, 8'hd8);
      pin_level <= 1'h1;
      cyc(20);
      pin_level <= 1'h0;
      cyc(10);
      apb(1'h0, CNT, 8'h0);
      v = q;
      check({31'h0, v > 32'h10 && v < 32'h18}, 32'h1);
      r(CTL, 8'hc8);
      pin_level <= 1'h1;
      cyc(10);
      pin_level <= 1'h0;
      cyc(10);
      r(CNT, v[7:0]);
      @(posedge pclk);
      warm_reset_n <= 1'h0;
      repeat (3) @(posedge pclk);
      warm_reset_n <= 1'h1;
      r(CTL, 8'hc8);
      r(CNT, v[7:0]);
      end_of_test();
   end
endmodule
bind etc8_timer etc8_checker #(.DIV_BITS(DIV_BITS)) u_chk (.pclk, .presetn, .warm_reset_n,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .count_pin, .freq_divider_out, .irq, .wake);
